// >>> rtl/uhs_seq.sv
// Host port state sequencer: operational entry and automatic suspend.
`timescale 1ns/10ps
`default_nettype none

module uhs_seq
	import uhs_pkg::*;
#(
	parameter int unsigned HS_SOF_CYCLES    = uhs_pkg::HS_SOF_CYC,
	parameter int unsigned FS_SOF_CYCLES    = uhs_pkg::FS_SOF_CYC,
	parameter int unsigned SUSP_WAIT_CYCLES = uhs_pkg::SUSP_WAIT_CYC
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [1:0] host_state_change_cmd,
	input  wire logic       cmd_write,
	input  wire logic [1:0] attached_port_speed,
	input  wire logic       remote_wakeup_accept_en,
	input  wire logic       transaction_busy,
	input  wire logic       suspend_done_clear,
	output logic [2:0]      host_state_monitor,
	output logic [1:0]      transceiver_speed_select,
	output logic            termination_select,
	output logic [1:0]      transceiver_op_mode,
	output logic            disconnect_det_en,
	output logic            remote_wakeup_det_en,
	output logic            suspend_done_flag,
	output logic            first_frame_pulse,
	output logic            frame_gen_en,
	output logic            frame_is_keepalive
);

	import uhs_pkg::*;

	typedef enum {
		UHS_ST_IDLE,
		UHS_ST_OP_WAIT,
		UHS_ST_OPERATIONAL,
		UHS_ST_SUSP_DRAIN,
		UHS_ST_SUSP_POWER,
		UHS_ST_SUSP_WAIT,
		UHS_ST_SUSPENDED
	} uhs_state_e;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	uhs_state_e state_q;
	uhs_state_e state_d;
	logic [2:0] host_state_q;
	logic [2:0] host_state_d;
	logic [1:0] xcvr_sel_q;
	logic [1:0] xcvr_sel_d;
	logic       term_sel_q;
	logic       term_sel_d;
	logic [1:0] op_mode_q;
	logic [1:0] op_mode_d;
	logic       disc_en_q;
	logic       disc_en_d;
	logic       wkup_en_q;
	logic       wkup_en_d;
	logic       susp_done_q;
	logic       susp_done_d;
	logic       first_frame_q;
	logic       first_frame_d;
	logic       frame_en_q;
	logic       frame_en_d;
	logic       keepalive_q;
	logic       keepalive_d;
	logic       hs_susp_q;
	logic       hs_susp_d;

	// ---------------------------------------------------------------
	// Command decode and timer control
	// ---------------------------------------------------------------
	wire              go_oper_w;
	wire              go_susp_w;
	wire              is_hs_w;
	wire              susp_done_set_w;
	wire              tmr_load_w;
	wire              pd_enter_w;
	wire [TMR_W-1:0]  tmr_cycles_w;
	wire              tmr_expired_w;

	assign go_oper_w = cmd_write && (host_state_change_cmd == CMD_ENTER_OPERATIONAL);
	assign go_susp_w = cmd_write && (host_state_change_cmd == CMD_ENTER_SUSPEND);
	assign is_hs_w   = (attached_port_speed == SPD_HS);

	assign pd_enter_w = !go_oper_w && !go_susp_w &&
		((state_q == UHS_ST_SUSP_POWER) ||
		((state_q == UHS_ST_SUSP_DRAIN) && !transaction_busy && !hs_susp_q));

	assign tmr_cycles_w = go_oper_w ?
		(is_hs_w ? TMR_W'(HS_SOF_CYCLES) : TMR_W'(FS_SOF_CYCLES)) :
		TMR_W'(SUSP_WAIT_CYCLES);

	assign tmr_load_w = go_oper_w || pd_enter_w;

	assign susp_done_set_w = (state_q == UHS_ST_SUSP_WAIT) && tmr_expired_w;

	uhs_timer #(
		.W (TMR_W)
	) u_timer (
		.clk         (clk),
		.nrst        (nrst),
		.load        (tmr_load_w),
		.load_cycles (tmr_cycles_w),
		.cancel      (go_susp_w),
		.expired     (tmr_expired_w)
	);

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_d       = state_q;
		host_state_d  = host_state_q;
		xcvr_sel_d    = xcvr_sel_q;
		term_sel_d    = term_sel_q;
		op_mode_d     = op_mode_q;
		disc_en_d     = disc_en_q;
		wkup_en_d     = wkup_en_q;
		first_frame_d = 1'b0;
		frame_en_d    = frame_en_q;
		keepalive_d   = keepalive_q;
		hs_susp_d     = hs_susp_q;

		if (go_oper_w) begin
			state_d      = UHS_ST_OP_WAIT;
			host_state_d = HST_OPERATIONAL;
			op_mode_d    = OPM_NORMAL;
			disc_en_d    = 1'b1;
			wkup_en_d    = 1'b0;
			frame_en_d   = 1'b0;
		end else if (go_susp_w) begin
			state_d      = UHS_ST_SUSP_DRAIN;
			host_state_d = HST_SUSPEND;
			disc_en_d    = 1'b0;
			wkup_en_d    = 1'b0;
			frame_en_d   = 1'b0;
			hs_susp_d    = is_hs_w;
		end else begin
			case (state_q)
				UHS_ST_IDLE: begin
					state_d = UHS_ST_IDLE;
				end
				UHS_ST_OP_WAIT: begin
					if (tmr_expired_w) begin
						state_d       = UHS_ST_OPERATIONAL;
						first_frame_d = 1'b1;
						frame_en_d    = 1'b1;
						keepalive_d   = (attached_port_speed == SPD_LS);
					end
				end
				UHS_ST_OPERATIONAL: begin
					keepalive_d = (attached_port_speed == SPD_LS);
				end
				UHS_ST_SUSP_DRAIN: begin
					if (!transaction_busy) begin
						if (hs_susp_q) begin
							xcvr_sel_d = SPD_FS;
							term_sel_d = TERM_FS;
							state_d    = UHS_ST_SUSP_POWER;
						end else begin
							op_mode_d  = OPM_POWER_DOWN;
							state_d    = UHS_ST_SUSP_WAIT;
						end
					end
				end
				UHS_ST_SUSP_POWER: begin
					op_mode_d = OPM_POWER_DOWN;
					state_d   = UHS_ST_SUSP_WAIT;
				end
				UHS_ST_SUSP_WAIT: begin
					if (tmr_expired_w) begin
						disc_en_d = 1'b1;
						wkup_en_d = remote_wakeup_accept_en;
						state_d   = UHS_ST_SUSPENDED;
					end
				end
				UHS_ST_SUSPENDED: begin
					state_d = UHS_ST_SUSPENDED;
				end
				default: begin
					state_d = UHS_ST_IDLE;
				end
			endcase
		end
	end

	// Both branches load the wait timer on the edge that sets power-down,
	// so the wait is measured from the first cycle the mode is visible.

	assign susp_done_d = susp_done_set_w || (susp_done_q && !suspend_done_clear);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q      <= UHS_ST_IDLE;
			host_state_q <= RST_HOST_STATE;
			xcvr_sel_q   <= RST_XCVR_SEL;
			term_sel_q   <= RST_TERM_SEL;
			op_mode_q    <= RST_OP_MODE;
			disc_en_q    <= 1'b0;
			wkup_en_q    <= 1'b0;
			susp_done_q  <= 1'b0;
			first_frame_q <= 1'b0;
			frame_en_q   <= 1'b0;
			keepalive_q  <= 1'b0;
			hs_susp_q    <= 1'b0;
		end else begin
			state_q      <= state_d;
			host_state_q <= host_state_d;
			xcvr_sel_q   <= xcvr_sel_d;
			term_sel_q   <= term_sel_d;
			op_mode_q    <= op_mode_d;
			disc_en_q    <= disc_en_d;
			wkup_en_q    <= wkup_en_d;
			susp_done_q  <= susp_done_d;
			first_frame_q <= first_frame_d;
			frame_en_q   <= frame_en_d;
			keepalive_q  <= keepalive_d;
			hs_susp_q    <= hs_susp_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign host_state_monitor       = host_state_q;
	assign transceiver_speed_select = xcvr_sel_q;
	assign termination_select       = term_sel_q;
	assign transceiver_op_mode      = op_mode_q;
	assign disconnect_det_en        = disc_en_q;
	assign remote_wakeup_det_en     = wkup_en_q;
	assign suspend_done_flag        = susp_done_q;
	assign first_frame_pulse        = first_frame_q;
	assign frame_gen_en             = frame_en_q;
	assign frame_is_keepalive       = keepalive_q;

endmodule : uhs_seq

`default_nettype wire

// >>> inc/uhs_pkg.sv
// Shared constants for the USB host port suspend sequencer.
package uhs_pkg;

	// ---------------------------------------------------------------
	// Clock
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 25000;

	// ---------------------------------------------------------------
	// Timing, figures in their own units and derived cycle counts
	// ---------------------------------------------------------------
	localparam int unsigned T_HS_SOF_MIN_NS   = 120000;
	localparam int unsigned T_HS_SOF_MAX_NS   = 130000;
	localparam int unsigned T_FS_SOF_MIN_NS   = 900000;
	localparam int unsigned T_FS_SOF_MAX_NS   = 1100000;
	localparam int unsigned T_SUSP_WAIT_MIN_NS = 5000000;

	// Strict lower bounds: one cycle past the rounded-up figure.
	localparam int unsigned HS_SOF_CYC =
		(T_HS_SOF_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
	localparam int unsigned HS_SOF_MAX_CYC = (T_HS_SOF_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned FS_SOF_CYC =
		(T_FS_SOF_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
	localparam int unsigned FS_SOF_MAX_CYC = (T_FS_SOF_MAX_NS * 1000) / CLK_PERIOD_PS;
	// Worked in nanoseconds, since the wait in picoseconds overflows 32 bits.
	localparam int unsigned SUSP_WAIT_CYC =
		(T_SUSP_WAIT_MIN_NS + CLK_PERIOD_PS / 1000 - 1) / (CLK_PERIOD_PS / 1000) + 1;

	localparam int unsigned TMR_W = 18;

	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] CMD_NONE          = 2'h0;
	localparam logic [1:0] CMD_ENTER_OPERATIONAL = 2'h1;
	localparam logic [1:0] CMD_ENTER_SUSPEND = 2'h2;

	localparam logic [2:0] HST_IDLE          = 3'h0;
	localparam logic [2:0] HST_OPERATIONAL   = 3'h1;
	localparam logic [2:0] HST_SUSPEND       = 3'h2;

	localparam logic [1:0] SPD_HS            = 2'h0;
	localparam logic [1:0] SPD_FS            = 2'h1;
	localparam logic [1:0] SPD_LS            = 2'h2;

	localparam logic       TERM_HS           = 1'b0;
	localparam logic       TERM_FS           = 1'b1;

	localparam logic [1:0] OPM_NORMAL        = 2'h0;
	localparam logic [1:0] OPM_POWER_DOWN    = 2'h3;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [2:0] RST_HOST_STATE    = HST_IDLE;
	localparam logic [1:0] RST_XCVR_SEL      = SPD_FS;
	localparam logic       RST_TERM_SEL      = TERM_FS;
	localparam logic [1:0] RST_OP_MODE       = OPM_NORMAL;

endpackage : uhs_pkg

// >>> rtl/uhs_timer.sv
// Down-counting one-shot timer with a single-cycle expiry pulse.
`timescale 1ns/10ps
`default_nettype none

module uhs_timer #(
	parameter int unsigned W = 18
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_cycles,
	input  wire logic         cancel,
	output logic              expired
);

	logic [W-1:0] remain_q;
	logic [W-1:0] remain_d;
	logic         run_q;
	logic         run_d;
	wire          last_w;

	// A load of N makes expired pulse N cycles after the load cycle.
	assign last_w   = run_q && (remain_q == {{(W-1){1'b0}}, 1'b1});
	assign expired  = last_w;
	assign remain_d = load ? load_cycles : (run_q ? remain_q - 1'b1 : remain_q);
	assign run_d    = load ? 1'b1 : ((cancel || last_w) ? 1'b0 : run_q);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			remain_q <= '0;
			run_q    <= 1'b0;
		end else begin
			remain_q <= remain_d;
			run_q    <= run_d;
		end
	end

endmodule : uhs_timer

`default_nettype wire

// >>> tb/uhs_seq_asserts.sv
// Port-level checker for the host port suspend sequencer.
`timescale 1ns/10ps
`default_nettype none
module uhs_seq_asserts
	import uhs_pkg::*;
#(
	parameter int HS_SOF_CYCLES    = 20,
	parameter int FS_SOF_CYCLES    = 60,
	parameter int SUSP_WAIT_CYCLES = 100
) (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic [1:0] host_state_change_cmd,
	input wire logic       cmd_write,
	input wire logic [1:0] attached_port_speed,
	input wire logic       remote_wakeup_accept_en,
	input wire logic       transaction_busy,
	input wire logic       suspend_done_clear,
	input wire logic [2:0] host_state_monitor,
	input wire logic [1:0] transceiver_speed_select,
	input wire logic       termination_select,
	input wire logic [1:0] transceiver_op_mode,
	input wire logic       disconnect_det_en,
	input wire logic       remote_wakeup_det_en,
	input wire logic       suspend_done_flag,
	input wire logic       first_frame_pulse,
	input wire logic       frame_gen_en,
	input wire logic       frame_is_keepalive
);
	localparam int WMAX = SUSP_WAIT_CYCLES + 4;
	wire op_w = cmd_write && host_state_change_cmd == CMD_ENTER_OPERATIONAL;
	wire su_w = cmd_write && host_state_change_cmd == CMD_ENTER_SUSPEND;
	wire pd_w = transceiver_op_mode == OPM_POWER_DOWN;
	// Counts power-down cycles so the rise of suspend_done_flag can be checked against a long minimum.
	logic [17:0] pd_cnt_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) pd_cnt_q <= 18'h0_0000;
		else pd_cnt_q <= pd_w ? pd_cnt_q + 18'h0_0001 : 18'h0_0000;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence fs_idle_s;
		su_w && attached_port_speed == SPD_FS && !transaction_busy ##1 !transaction_busy;
	endsequence
	sequence hs_idle_s;
		su_w && attached_port_speed == SPD_HS && !transaction_busy ##1 !transaction_busy [*2];
	endsequence
	susp_entry_a: assert property (su_w |=> host_state_monitor == HST_SUSPEND
		&& !disconnect_det_en && !remote_wakeup_det_en) else $error("suspend entry wrong");
	oper_entry_a: assert property (op_w |=> host_state_monitor == HST_OPERATIONAL
		&& transceiver_op_mode == OPM_NORMAL && disconnect_det_en) else $error("oper entry wrong");
	hs_sof_a: assert property (op_w && attached_port_speed == SPD_HS
		|=> ##HS_SOF_CYCLES first_frame_pulse) else $error("hs first frame time");
	fs_sof_a: assert property (op_w && attached_port_speed != SPD_HS
		|=> ##FS_SOF_CYCLES first_frame_pulse && frame_gen_en) else $error("fs first frame time");
	fs_pd_a: assert property (fs_idle_s |=> pd_w) else $error("fs power-down late");
	hs_pd_a: assert property (hs_idle_s |=> pd_w) else $error("hs power-down late");
	pd_sel_a: assert property ($rose(pd_w) |-> transceiver_speed_select == SPD_FS
		&& termination_select == TERM_FS && !$past(transaction_busy)) else $error("pd order");
	wait_min_a: assert property ($rose(suspend_done_flag) |-> disconnect_det_en
		&& pd_cnt_q >= SUSP_WAIT_CYCLES) else $error("suspend wait too short");
	wake_sel_a: assert property ($rose(suspend_done_flag)
		|-> remote_wakeup_det_en == remote_wakeup_accept_en) else $error("wakeup enable wrong");
	auto_done_a: assert property ($rose(pd_w)
		|-> ##[1:WMAX] $rose(suspend_done_flag)) else $error("suspend not completed");
	pulse_one_a: assert property (first_frame_pulse |=> !first_frame_pulse)
		else $error("first frame pulse too long");
endmodule : uhs_seq_asserts
bind uhs_seq uhs_seq_asserts #(.HS_SOF_CYCLES(HS_SOF_CYCLES), .FS_SOF_CYCLES(FS_SOF_CYCLES),
	.SUSP_WAIT_CYCLES(SUSP_WAIT_CYCLES)) uhs_seq_asserts_inst (.clk(clk), .nrst(nrst),
	.host_state_change_cmd(host_state_change_cmd), .cmd_write(cmd_write),
	.attached_port_speed(attached_port_speed), .remote_wakeup_accept_en(remote_wakeup_accept_en),
	.transaction_busy(transaction_busy), .suspend_done_clear(suspend_done_clear),
	.host_state_monitor(host_state_monitor), .transceiver_speed_select(transceiver_speed_select),
	.termination_select(termination_select), .transceiver_op_mode(transceiver_op_mode),
	.disconnect_det_en(disconnect_det_en), .remote_wakeup_det_en(remote_wakeup_det_en),
	.suspend_done_flag(suspend_done_flag), .first_frame_pulse(first_frame_pulse),
	.frame_gen_en(frame_gen_en), .frame_is_keepalive(frame_is_keepalive));
`default_nettype wire

// >>> tb/uhs_dev_model.sv
// Attached device model: transaction activity and idle detection.
`timescale 1ns/10ps
`default_nettype none
module uhs_dev_model
	import uhs_pkg::*;
#(
	parameter int DET_CYC = 60
) (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       start,
	input wire logic [7:0] busy_len,
	input wire logic [1:0] op_mode,
	output logic           busy,
	output logic           dev_susp
);
	logic [7:0] bcnt_q;
	logic [7:0] icnt_q;
	assign busy = bcnt_q != 8'h00;
	assign dev_susp = icnt_q == 8'(DET_CYC);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bcnt_q <= 8'h00;
			icnt_q <= 8'h00;
		end else begin
			bcnt_q <= start ? busy_len : bcnt_q - {7'h00, busy};
			icnt_q <= op_mode != OPM_POWER_DOWN ? 8'h00 : icnt_q + {7'h00, !dev_susp};
		end
	end
endmodule : uhs_dev_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the host port suspend sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import uhs_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, cmd_write = 1'b0, wk_en = 1'b0, clr = 1'b0, start = 1'b0;
	logic [1:0] cmd = CMD_NONE, speed = SPD_HS, xsel, opm;
	logic [7:0] blen = 8'h00;
	logic [2:0] hst;
	logic busy, dev_susp, dde, rwe, done, ffp, fge, fka, term, pd;
	int mismatches = 0, tests_run = 0;
	always_comb pd = opm == OPM_POWER_DOWN;
	uhs_seq #(.HS_SOF_CYCLES(20), .FS_SOF_CYCLES(60), .SUSP_WAIT_CYCLES(100)) uhs_seq_inst (
		.clk(clk), .nrst(nrst), .host_state_change_cmd(cmd), .cmd_write(cmd_write),
		.attached_port_speed(speed), .remote_wakeup_accept_en(wk_en),
		.transaction_busy(busy), .suspend_done_clear(clr), .host_state_monitor(hst),
		.transceiver_speed_select(xsel), .termination_select(term), .transceiver_op_mode(opm),
		.disconnect_det_en(dde), .remote_wakeup_det_en(rwe), .suspend_done_flag(done),
		.first_frame_pulse(ffp), .frame_gen_en(fge), .frame_is_keepalive(fka));
	uhs_dev_model uhs_dev_model_inst (.clk(clk), .nrst(nrst), .start(start), .busy_len(blen),
		.op_mode(opm), .busy(busy), .dev_susp(dev_susp));
	task automatic wrap_up;
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic issue(input logic [1:0] c, input logic [7:0] b);
		@(negedge clk);
		cmd = c;
		cmd_write = 1'b1;
		start = b != 8'h00;
		blen = b;
		@(negedge clk);
		cmd_write = 1'b0;
		start = 1'b0;
	endtask : issue
	// Counts edges from the take edge to the one that shows s; a bound that runs out ends the run.
	task automatic wait_for(ref logic s, input int lim, output int n);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (s !== 1'b1) begin
			chk(1'b0, "wait timed out");
			wrap_up();
		end
	endtask : wait_for
	task automatic clear_flag;
		@(negedge clk);
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		chk(done === 1'b0, "flag not cleared");
	endtask : clear_flag
	task automatic t_oper(input logic [1:0] sp, input int n_exp);
		int n;
		speed = sp;
		issue(CMD_ENTER_OPERATIONAL, 8'h00);
		chk(hst === HST_OPERATIONAL && opm === OPM_NORMAL && dde === 1'b1, "oper entry");
		wait_for(ffp, 200, n);
		chk(n == n_exp && fge === 1'b1, "first frame time");
		chk(fka === (sp == SPD_LS), "frame kind");
	endtask : t_oper
	task automatic t_susp_busy;
		int n;
		speed = SPD_HS;
		wk_en = 1'b1;
		issue(CMD_ENTER_SUSPEND, 8'h05);
		chk(hst === HST_SUSPEND && dde === 1'b0 && rwe === 1'b0, "suspend entry");
		wait_for(pd, 50, n);
		chk(n == 7 && xsel === SPD_FS && term === TERM_FS, "power-down order");
		wait_for(done, 200, n);
		chk(n >= 100 && dde === 1'b1 && rwe === 1'b1, "suspend end");
		chk(dev_susp === 1'b1, "device not idle");
		clear_flag();
	endtask : t_susp_busy
	task automatic t_susp_idle(input logic [1:0] sp, input int n_pd);
		int n;
		speed = sp;
		wk_en = 1'b0;
		issue(CMD_ENTER_SUSPEND, 8'h00);
		wait_for(pd, 50, n);
		chk(n == n_pd && xsel === SPD_FS && term === TERM_FS, "idle power-down");
		wait_for(done, 200, n);
		chk(n >= 100 && dde === 1'b1 && rwe === 1'b0, "wakeup not off");
		clear_flag();
	endtask : t_susp_idle
	initial begin
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (16) @(negedge clk);
		chk(hst === RST_HOST_STATE && xsel === RST_XCVR_SEL && term === RST_TERM_SEL
			&& opm === RST_OP_MODE && dde === 1'b0 && done === 1'b0, "reset values");
		nrst = 1'b1;
		t_oper(SPD_HS, 20);
		t_oper(SPD_FS, 60);
		t_oper(SPD_LS, 60);
		t_susp_busy();
		t_oper(SPD_FS, 60);
		t_susp_idle(SPD_FS, 1);
		t_oper(SPD_HS, 20);
		t_susp_idle(SPD_HS, 2);
		wrap_up();
	end
endmodule : tb
`default_nettype wire
